// ### dv/slst_rx_model.sv
// slst_rx_model: receiver-side watcher of lmfc spacing and timestamp bits
`timescale 1ns/1ps
`default_nettype none
module slst_rx_model (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       lmfc_tick,
	input  wire logic       ts_mark,
	input  wire logic [2:0] ctrl_bits,
	output logic      [7:0] period,
	output logic      [2:0] ts_bits
);
	logic [7:0] cnt_r;
	// buffer release keys on lmfc; spread must fit in one period
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_r   <= 8'h00;
			period  <= 8'h00;
			ts_bits <= 3'h0;
		end else begin
			cnt_r <= lmfc_tick ? 8'h01 : cnt_r + 8'h01;
			if (lmfc_tick)
				period <= cnt_r;
			if (ts_mark)
				ts_bits <= ctrl_bits;
		end
	end
endmodule // slst_rx_model
`default_nettype wire

// ### dv/tb_top.sv
// tb_top: self-checking bench for the sysref/lmfc sync block
`timescale 1ns/1ps
`default_nettype none
module tb_top import slst_pkg::*;;
	logic        mclk, rst, reg_wr, reg_rd, sysref;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, sh_status, rx_per;
	logic        frame_tick, lmfc_tick, div_sync, sync_all, ts_mark;
	logic [2:0]  ctrl_bits, rx_ts;
	int          fail_count = 0;
	int          n_tests = 0;
	int          n, n0, d0;
	int          dsc = 0;

	slst_top DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sysref(sysref), .sh_status(sh_status),
		.frame_tick(frame_tick), .lmfc_tick(lmfc_tick),
		.div_sync(div_sync), .sync_all(sync_all), .ctrl_bits(ctrl_bits),
		.ts_mark(ts_mark));
	slst_rx_model rx (.mclk(mclk), .rst(rst), .lmfc_tick(lmfc_tick),
		.ts_mark(ts_mark), .ctrl_bits(ctrl_bits), .period(rx_per),
		.ts_bits(rx_ts));

	// counted mid-cycle so task returns at the edge never race it
	always @(negedge mclk)
		if (div_sync === 1'b1)
			dsc++;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] d;
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		chk(d, exp);
		@(posedge mclk);
	endtask
	// sel 0 div_sync, 1 lmfc_tick, 2 ts_mark; cnt 0 means never seen
	task automatic wait_ev(input int sel, input int lim, output int cnt);
		logic [2:0] ev;
		cnt = 0;
		for (int i = 1; i <= lim && cnt == 0; i++) begin
			@(posedge mclk);
			#1 ev = {ts_mark, lmfc_tick, div_sync};
			if (ev[sel] === 1'b1)
				cnt = i;
		end
	endtask
	// low time keeps the next rising transition clean
	task automatic rel();
		@(posedge mclk);
		sysref <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	task automatic t_regs();
		rc(SLST_A_SUBC, 8'h20);
		rc(SLST_A_SYNC, 8'h00);
		rc(SLST_A_CAP, 8'h00);
		wr(SLST_A_LMFC, 8'hff);
		rc(SLST_A_LMFC, 8'h1f);
		wr(SLST_A_SHS, 8'h00);
		rc(SLST_A_SHS, 8'h5a);
		wr(12'h7ff, 8'hff);
		rc(12'h7ff, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_align();
		int f[4] = '{4, 1, 2, 4};
		int o[4] = '{3, 7, 3, 9};
		int p[4] = '{3, 4, 2, 1};
		wr(SLST_A_FPM, 8'h07);
		wr(SLST_A_CAP, 8'h02);
		for (int i = 0; i < 4; i++) begin
			wr(SLST_A_OPF, 8'(f[i]));
			wr(SLST_A_LMFC, 8'(o[i]));
			sysref <= 1'b1;
			wait_ev(0, 12, n);
			chk(8'(n > 0), 8'h01);
			chk({7'h0, sync_all}, 8'h01);
			wait_ev(1, 40, n);
			chk(8'(n), 8'(p[i] + 1));
			chk({7'h0, frame_tick}, 8'h01);
			wait_ev(1, 40, n);
			rel();
			chk(rx_per, 8'h08);
		end
		$display("test align done");
	endtask
	task automatic t_stamp();
		logic [7:0] lo[3] = '{8'h05, 8'h50, 8'h00};
		wr(SLST_A_CAP, 8'h02);
		wr(SLST_A_CBPS, 8'hc0);
		wr(SLST_A_SYNC, 8'h01);
		for (int i = 0; i < 3; i++) begin
			wr(SLST_A_CBF_LO, lo[i]);
			wr(SLST_A_CBF_HI, (i == 2) ? 8'h05 : 8'h00);
			wr(SLST_A_TSD, 8'(i));
			d0 = dsc;
			sysref <= 1'b1;
			wait_ev(2, 30, n);
			if (i == 0)
				n0 = n;
			chk(8'(n - n0), 8'(i));
			chk({5'h0, ctrl_bits}, 8'(1 << i));
			rel();
			chk({5'h0, rx_ts}, 8'(1 << i));
			chk(8'(dsc - d0), 8'h00);
		end
		wr(SLST_A_DEC, 8'h01);
		sysref <= 1'b1;
		wait_ev(2, 30, n);
		chk(8'(n), 8'h00);
		rel();
		wr(SLST_A_DEC, 8'h00);
		wr(SLST_A_SYNC, 8'h00);
		$display("test stamp done");
	endtask
	task automatic t_edges();
		wr(SLST_A_CAP, 8'h12);
		sysref <= 1'b1;
		wait_ev(0, 12, n);
		chk(8'(n), 8'h00);
		d0 = dsc;
		rel();
		chk(8'(dsc - d0), 8'h01);
		d0 = dsc;
		sysref <= 1'b1;
		repeat (4) @(posedge mclk);
		rel();
		chk(8'(dsc - d0), 8'h01);
		wr(SLST_A_CAP, 8'h1a);
		rc(SLST_A_CAP, 8'h1a);
		d0 = dsc;
		sysref <= 1'b1;
		repeat (4) @(posedge mclk);
		rel();
		repeat (4) @(posedge mclk);
		chk(8'(dsc - d0), 8'h01);
		$display("test edges done");
	endtask
	task automatic t_nshot();
		wr(SLST_A_IGN, 8'h01);
		wr(SLST_A_CAP, 8'h04);
		for (int i = 0; i < 3; i++) begin
			sysref <= 1'b1;
			wait_ev(0, 12, n);
			chk(8'(n > 0), 8'(i == 1));
			rel();
		end
		rc(SLST_A_CAP, 8'h00);
		$display("test nshot done");
	endtask
	task automatic t_sub0();
		wr(SLST_A_CAP, 8'h02);
		wr(SLST_A_SUBC, 8'h00);
		sysref <= 1'b1;
		wait_ev(0, 12, n);
		chk(8'(n), 8'h00);
		wait_ev(1, 40, n);
		chk(8'(n > 0), 8'h01);
		rel();
		rc(SLST_A_SUBC, 8'h00);
		$display("test sub0 done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		rst       = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 12'h000;
		reg_wdata = 8'h00;
		sysref    = 1'b0;
		sh_status = 8'h5a;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_regs();
		t_align();
		t_stamp();
		t_edges();
		t_nshot();
		t_sub0();
		finish_test();
	end
	// whole run is about three hundred and thirty cycles
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		finish_test();
	end
endmodule // tb_top
`default_nettype wire

// ### rtl/slst_cap_if.sv
// slst_cap_if: settings and events between control and sysref capture
`timescale 1ns/1ps
`default_nettype none
interface slst_cap_if;
	logic       sysref;
	logic       edge_sel;
	logic       trans_sel;
	logic [1:0] mode;
	logic [3:0] ignore_n;
	logic       event_p;
	logic       done_p;
	modport cap (input sysref, edge_sel, trans_sel, mode, ignore_n,
		output event_p, done_p);
	modport ctl (output sysref, edge_sel, trans_sel, mode, ignore_n,
		input event_p, done_p);
endinterface
`default_nettype wire

// ### rtl/slst_pkg.sv
// slst_pkg: register map, fields, codes and reset values of the sync block
package slst_pkg;
	localparam logic [11:0] SLST_A_CAP    = 12'h120;
	localparam logic [11:0] SLST_A_IGN    = 12'h121;
	localparam logic [11:0] SLST_A_TSD    = 12'h123;
	localparam logic [11:0] SLST_A_SHS    = 12'h128;
	localparam logic [11:0] SLST_A_SYNC   = 12'h1ff;
	localparam logic [11:0] SLST_A_CBF_LO = 12'h559;
	localparam logic [11:0] SLST_A_CBF_HI = 12'h55a;
	localparam logic [11:0] SLST_A_LMFC   = 12'h578;
	localparam logic [11:0] SLST_A_CBPS   = 12'h58f;
	localparam logic [11:0] SLST_A_SUBC   = 12'h590;
	localparam logic [11:0] SLST_A_OPF    = 12'h600;
	localparam logic [11:0] SLST_A_FPM    = 12'h601;
	localparam logic [11:0] SLST_A_SPF    = 12'h602;
	localparam logic [11:0] SLST_A_DEC    = 12'h603;
	localparam logic [11:0] SLST_A_STAT   = 12'h604;
	localparam int SLST_CAP_TRANS = 4;
	localparam int SLST_CAP_EDGE  = 3;
	localparam int SLST_CAP_MODE  = 1;
	localparam int SLST_SUBC_BIT  = 5;
	localparam int SLST_SYNC_BIT  = 0;
	localparam int SLST_CBPS_LO   = 6;
	localparam int SLST_CBF1_LO   = 4;
	localparam logic [7:0] SLST_CAP_MASK  = 8'h1e;
	localparam logic [7:0] SLST_IGN_MASK  = 8'h0f;
	localparam logic [7:0] SLST_SYNC_MASK = 8'h01;
	localparam logic [7:0] SLST_CBFL_MASK = 8'h77;
	localparam logic [7:0] SLST_CBFH_MASK = 8'h07;
	localparam logic [7:0] SLST_LMFC_MASK = 8'h1f;
	localparam logic [7:0] SLST_CBPS_MASK = 8'hc0;
	localparam logic [7:0] SLST_SUBC_MASK = 8'h20;
	localparam logic [7:0] SLST_OPF_MASK  = 8'h1f;
	localparam logic [7:0] SLST_FPM_MASK  = 8'h1f;
	localparam logic [7:0] SLST_SPF_MASK  = 8'h0f;
	localparam logic [7:0] SLST_DEC_MASK  = 8'h01;
	localparam logic [7:0] SLST_SUBC_RST  = 8'h20;
	localparam logic [7:0] SLST_OPF_RST   = 8'h04;
	localparam logic [7:0] SLST_FPM_RST   = 8'h1f;
	localparam logic [7:0] SLST_ZERO_RST  = 8'h00;
	localparam logic [1:0] SLST_SR_OFF    = 2'h0;
	localparam logic [1:0] SLST_SR_CONT   = 2'h1;
	localparam logic [1:0] SLST_SR_NSHOT  = 2'h2;
	localparam logic [2:0] SLST_CB_SYSREF = 3'h5;
	localparam logic [4:0] SLST_F_ONE     = 5'h01;
	localparam logic [4:0] SLST_F_TWO     = 5'h02;
	localparam logic [4:0] SLST_F1_STEP   = 5'h1c;
	localparam logic [4:0] SLST_F2_STEP   = 5'h1e;
	localparam int SLST_NCB = 3;
endpackage

// ### rtl/slst_sysref_cap.sv
// slst_sysref_cap: sysref sampling, transition qualify and n-shot ignore
`timescale 1ns/1ps
`default_nettype none
module slst_sysref_cap
	import slst_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	slst_cap_if.cap   cif
);
	logic       neg_r;
	logic       smp_r;
	logic       prev_r;
	logic [3:0] ign_r;
	logic       ev_r;
	logic       dn_r;
	logic       smp_nxt;
	logic       qual_w;
	logic       nshot_w;
	logic       pass_w;

	// falling-edge capture buys half a period of setup margin
	always_ff @(negedge mclk) begin
		neg_r <= cif.sysref;
	end

	assign smp_nxt = cif.edge_sel ? neg_r : cif.sysref;
	assign qual_w  = cif.trans_sel ? (prev_r & ~smp_r)
		: (smp_r & ~prev_r);
	assign nshot_w = (cif.mode == SLST_SR_NSHOT);
	assign pass_w  = nshot_w ? (ign_r == cif.ignore_n)
		: (cif.mode == SLST_SR_CONT);

	always_ff @(posedge mclk) begin
		if (rst) begin
			smp_r  <= 1'b0;
			prev_r <= 1'b0;
			ign_r  <= 4'h0;
			ev_r   <= 1'b0;
			dn_r   <= 1'b0;
		end else begin
			smp_r  <= smp_nxt;
			prev_r <= smp_r;
			ev_r   <= qual_w & pass_w;
			dn_r   <= qual_w & pass_w & nshot_w;
			if (!nshot_w || (qual_w && pass_w))
				ign_r <= 4'h0;
			else if (qual_w)
				ign_r <= ign_r + 4'h1;
		end
	end

	assign cif.event_p = ev_r;
	assign cif.done_p  = dn_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	cont_event_a: assert property ((cif.mode == SLST_SR_CONT) && qual_w
		|=> cif.event_p) else $error("continuous edge gave no event");
	nshot_done_a: assert property (cif.done_p |-> cif.event_p)
		else $error("n-shot done without event");
endmodule // slst_sysref_cap
`default_nettype wire

// ### rtl/slst_top.sv
// slst_top: lmfc, subclass, sync mode and sysref timestamp control
//
// Summary of operation
// - subclass bit: 1 selects subclass 1, default
// - subclass 0 runs fine without any sysref
// - subclass 1 sysref realigns lmfc and dividers
// - each lmfc period starts a multiframe
// - five-bit offset delays lmfc in frames
// - one octet per frame: steps of four
// - two octets per frame: even steps only
// - other frame sizes: one frame per step
// - bit picks rising or falling sysref transition
// - bit picks device clock sampling edge
// - sync mode resets to normal, 1 timestamps
// - timestamp mode flags sample, no clock reset
// - function code 5 routes timestamp flag
// - flag sysref sample, same latency everywhere
// - delay register moves the flagged sample
// - no timestamp while decimating
// - mode codes 1/2 arm; n-shot self-clears
// - normal mode sysref syncs divider, ddc, link
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module slst_top
	import slst_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        sysref,
	input  wire logic [7:0]  sh_status,
	output logic             frame_tick,
	output logic             lmfc_tick,
	output logic             div_sync,
	output logic             sync_all,
	output logic      [2:0]  ctrl_bits,
	output logic             ts_mark
);
	typedef enum {TS_IDLE, TS_WAIT} slst_ts_e;

	logic [7:0] cap_r;
	logic [7:0] ign_r;
	logic [7:0] tsd_r;
	logic [7:0] shs_r;
	logic [7:0] sync_r;
	logic [7:0] cbfl_r;
	logic [7:0] cbfh_r;
	logic [7:0] lmfc_r;
	logic [7:0] cbps_r;
	logic [7:0] subc_r;
	logic [7:0] opf_r;
	logic [7:0] fpm_r;
	logic [7:0] spf_r;
	logic [7:0] dec_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] cap_nxt;
	logic [7:0] stat_w;
	logic       aligned_r;
	logic [3:0] spf_cnt_r;
	logic [4:0] frm_cnt_r;
	logic       frame_r;
	logic       lmfc_r_o;
	logic       div_sync_r;
	logic       sync_all_r;
	logic [2:0] ctrl_bits_r;
	logic [2:0] ctrl_nxt;
	logic       mark_r;
	logic       mark_nxt;
	logic [7:0] ts_cnt_r;
	slst_ts_e   ts_st_r;
	slst_ts_e   ts_st_nxt;

	slst_cap_if cif();

	wire w_cap  = reg_wr && (reg_addr == SLST_A_CAP);
	wire w_ign  = reg_wr && (reg_addr == SLST_A_IGN);
	wire w_tsd  = reg_wr && (reg_addr == SLST_A_TSD);
	wire w_sync = reg_wr && (reg_addr == SLST_A_SYNC);
	wire w_cbfl = reg_wr && (reg_addr == SLST_A_CBF_LO);
	wire w_cbfh = reg_wr && (reg_addr == SLST_A_CBF_HI);
	wire w_lmfc = reg_wr && (reg_addr == SLST_A_LMFC);
	wire w_cbps = reg_wr && (reg_addr == SLST_A_CBPS);
	wire w_subc = reg_wr && (reg_addr == SLST_A_SUBC);
	wire w_opf  = reg_wr && (reg_addr == SLST_A_OPF);
	wire w_fpm  = reg_wr && (reg_addr == SLST_A_FPM);
	wire w_spf  = reg_wr && (reg_addr == SLST_A_SPF);
	wire w_dec  = reg_wr && (reg_addr == SLST_A_DEC);

	wire       sub1_w  = subc_r[SLST_SUBC_BIT];
	wire       tsmode_w = sync_r[SLST_SYNC_BIT];
	wire       decim_w = dec_r[0];
	wire [4:0] f_w     = opf_r[4:0];
	wire [4:0] kmax_w  = fpm_r[4:0];
	wire [3:0] smax_w  = spf_r[3:0];
	wire [1:0] cs_w    = cbps_r[SLST_CBPS_LO+:2];

	// sysref is ignored for alignment in subclass 0 and timestamp mode
	wire align_w = cif.event_p && sub1_w && !tsmode_w;
	// timestamping only exists at full bandwidth
	wire ts_go_w = cif.event_p && tsmode_w && !decim_w;

	// offset rounded down to the step that the frame size allows
	wire [4:0] off_w = lmfc_r[4:0];
	wire [4:0] eff_w = (f_w == SLST_F_ONE) ? (off_w & SLST_F1_STEP)
		: (f_w == SLST_F_TWO) ? (off_w & SLST_F2_STEP)
		: off_w;
	wire [5:0] k6_w    = {1'b0, kmax_w} + 6'h01;
	wire [5:0] ph6_w   = {1'b0, eff_w} % k6_w;
	wire [4:0] phase_w = ph6_w[4:0];

	wire frame_w = (spf_cnt_r == 4'h0);
	wire mfs_w   = frame_w && (frm_cnt_r == phase_w);

	assign cif.sysref    = sysref;
	assign cif.edge_sel  = cap_r[SLST_CAP_EDGE];
	assign cif.trans_sel = cap_r[SLST_CAP_TRANS];
	assign cif.mode      = cap_r[SLST_CAP_MODE+:2];
	assign cif.ignore_n  = ign_r[3:0];

	slst_sysref_cap u_cap (
		.mclk (mclk),
		.rst  (rst),
		.cif  (cif)
	);

	// a software write of the mode field wins over the n-shot self-clear
	always_comb begin
		cap_nxt = cap_r;
		if (w_cap)
			cap_nxt = reg_wdata & SLST_CAP_MASK;
		else if (cif.done_p)
			cap_nxt[SLST_CAP_MODE+:2] = SLST_SR_OFF;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cap_r  <= SLST_ZERO_RST;
			ign_r  <= SLST_ZERO_RST;
			tsd_r  <= SLST_ZERO_RST;
			sync_r <= SLST_ZERO_RST;
			cbfl_r <= SLST_ZERO_RST;
			cbfh_r <= SLST_ZERO_RST;
			lmfc_r <= SLST_ZERO_RST;
			cbps_r <= SLST_ZERO_RST;
			subc_r <= SLST_SUBC_RST;
			opf_r  <= SLST_OPF_RST;
			fpm_r  <= SLST_FPM_RST;
			spf_r  <= SLST_ZERO_RST;
			dec_r  <= SLST_ZERO_RST;
			shs_r  <= SLST_ZERO_RST;
		end else begin
			cap_r <= cap_nxt;
			shs_r <= sh_status;
			if (w_ign)  ign_r  <= reg_wdata & SLST_IGN_MASK;
			if (w_tsd)  tsd_r  <= reg_wdata;
			if (w_sync) sync_r <= reg_wdata & SLST_SYNC_MASK;
			if (w_cbfl) cbfl_r <= reg_wdata & SLST_CBFL_MASK;
			if (w_cbfh) cbfh_r <= reg_wdata & SLST_CBFH_MASK;
			if (w_lmfc) lmfc_r <= reg_wdata & SLST_LMFC_MASK;
			if (w_cbps) cbps_r <= reg_wdata & SLST_CBPS_MASK;
			if (w_subc) subc_r <= reg_wdata & SLST_SUBC_MASK;
			if (w_opf)  opf_r  <= reg_wdata & SLST_OPF_MASK;
			if (w_fpm)  fpm_r  <= reg_wdata & SLST_FPM_MASK;
			if (w_spf)  spf_r  <= reg_wdata & SLST_SPF_MASK;
			if (w_dec)  dec_r  <= reg_wdata & SLST_DEC_MASK;
		end
	end

	assign stat_w = {6'h00, (ts_st_r == TS_WAIT), aligned_r};

	always_comb begin
		rdata_nxt = 8'h00;
		if (!reg_rd)
			rdata_nxt = 8'h00;
		else if (reg_addr == SLST_A_CAP)
			rdata_nxt = cap_r;
		else if (reg_addr == SLST_A_IGN)
			rdata_nxt = ign_r;
		else if (reg_addr == SLST_A_TSD)
			rdata_nxt = tsd_r;
		else if (reg_addr == SLST_A_SHS)
			rdata_nxt = shs_r;
		else if (reg_addr == SLST_A_SYNC)
			rdata_nxt = sync_r;
		else if (reg_addr == SLST_A_CBF_LO)
			rdata_nxt = cbfl_r;
		else if (reg_addr == SLST_A_CBF_HI)
			rdata_nxt = cbfh_r;
		else if (reg_addr == SLST_A_LMFC)
			rdata_nxt = lmfc_r;
		else if (reg_addr == SLST_A_CBPS)
			rdata_nxt = cbps_r;
		else if (reg_addr == SLST_A_SUBC)
			rdata_nxt = subc_r;
		else if (reg_addr == SLST_A_OPF)
			rdata_nxt = opf_r;
		else if (reg_addr == SLST_A_FPM)
			rdata_nxt = fpm_r;
		else if (reg_addr == SLST_A_SPF)
			rdata_nxt = spf_r;
		else if (reg_addr == SLST_A_DEC)
			rdata_nxt = dec_r;
		else if (reg_addr == SLST_A_STAT)
			rdata_nxt = stat_w;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end

	// frame and multiframe counters restart on an accepted alignment
	always_ff @(posedge mclk) begin
		if (rst || align_w) begin
			spf_cnt_r <= 4'h0;
			frm_cnt_r <= 5'h00;
		end else begin
			spf_cnt_r <= (spf_cnt_r >= smax_w) ? 4'h0 : spf_cnt_r + 4'h1;
			if (frame_w)
				frm_cnt_r <= (frm_cnt_r >= kmax_w) ? 5'h00
					: frm_cnt_r + 5'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			frame_r    <= 1'b0;
			lmfc_r_o   <= 1'b0;
			div_sync_r <= 1'b0;
			sync_all_r <= 1'b0;
			aligned_r  <= 1'b0;
		end else begin
			frame_r    <= frame_w;
			lmfc_r_o   <= mfs_w;
			div_sync_r <= align_w;
			sync_all_r <= align_w;
			aligned_r  <= aligned_r | align_w;
		end
	end

	// delay 0 flags the sample one cycle after the event pulse
	always_comb begin
		ts_st_nxt = ts_st_r;
		mark_nxt  = 1'b0;
		case (ts_st_r)
			TS_IDLE: begin
				if (ts_go_w && (tsd_r == 8'h00))
					mark_nxt = 1'b1;
				else if (ts_go_w)
					ts_st_nxt = TS_WAIT;
			end
			TS_WAIT: begin
				if (ts_cnt_r == 8'h00) begin
					mark_nxt  = !decim_w;
					ts_st_nxt = TS_IDLE;
				end
			end
			default: ts_st_nxt = TS_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ts_st_r  <= TS_IDLE;
			ts_cnt_r <= 8'h00;
			mark_r   <= 1'b0;
		end else begin
			ts_st_r <= ts_st_nxt;
			mark_r  <= mark_nxt;
			if (ts_st_r == TS_IDLE)
				ts_cnt_r <= tsd_r - 8'h01;
			else
				ts_cnt_r <= ts_cnt_r - 8'h01;
		end
	end

	// one shared flag for all channels keeps their latency equal
	genvar gi;
	generate
		for (gi = 0; gi < SLST_NCB; gi++) begin : g_cb
			wire [2:0] fn_w = (gi == 0) ? cbfl_r[2:0]
				: (gi == 1) ? cbfl_r[SLST_CBF1_LO+:3] : cbfh_r[2:0];
			assign ctrl_nxt[gi] = mark_nxt && (cs_w > 2'(gi))
				&& (fn_w == SLST_CB_SYSREF);
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst)
			ctrl_bits_r <= 3'h0;
		else
			ctrl_bits_r <= ctrl_nxt;
	end

	assign reg_rdata  = rdata_r;
	assign frame_tick = frame_r;
	assign lmfc_tick  = lmfc_r_o;
	assign div_sync   = div_sync_r;
	assign sync_all   = sync_all_r;
	assign ctrl_bits  = ctrl_bits_r;
	assign ts_mark    = mark_r;

	default clocking dcb @(posedge mclk); endclocking
	default disable iff (rst);

	subc_rst_a: assert property ($past(rst) |-> sub1_w && !tsmode_w)
		else $error("subclass or sync mode reset value wrong");

	sequence s_resync;
		div_sync_r && sync_all_r ##1 frame_r;
	endsequence
	sc0_quiet_a: assert property (cif.event_p && !sub1_w |=> !div_sync_r)
		else $error("subclass 0 sysref realigned");
	align_seq_a: assert property (align_w |=> s_resync)
		else $error("alignment did not restart dividers");
	lmfc_zero_a: assert property (align_w && (phase_w == 5'h00)
		&& !w_lmfc && !w_opf && !w_fpm |-> ##2 lmfc_tick)
		else $error("lmfc not at multiframe start");
	f1_step_a: assert property ((f_w == SLST_F_ONE) |-> eff_w[1:0] == 2'h0)
		else $error("f=1 offset not a multiple of four");
	f2_step_a: assert property ((f_w == SLST_F_TWO) |-> !eff_w[0])
		else $error("f=2 offset odd");
	plain_step_a: assert property ((f_w > SLST_F_TWO) |-> eff_w == off_w)
		else $error("offset changed for wide frame");
	ts_noreset_a: assert property (cif.event_p && tsmode_w
		|=> !div_sync_r [*2]) else $error("timestamp mode reset clocks");
	ts_mark0_a: assert property (ts_go_w && (tsd_r == 8'h00)
		&& (ts_st_r == TS_IDLE) |=> ts_mark) else $error("no mark");
	cb_route_a: assert property (ts_mark && ($past(cs_w) != 2'h0)
		&& ($past(cbfl_r[2:0]) == SLST_CB_SYSREF) |-> ctrl_bits[0])
		else $error("control bit 0 missed the flag");
	decim_mark_a: assert property (decim_w && !w_dec |=> !ts_mark)
		else $error("mark while decimating");
	nshot_clr_a: assert property (cif.done_p && !w_cap
		|=> cif.mode == SLST_SR_OFF) else $error("n-shot did not clear");
endmodule // slst_top
`default_nettype wire
